// ==== smseq_top.sv ====
// smseq_top: exposure and readout sequencer with power state tracking.
// assumes trig_i and the avalon master are synchronous to clk_i; trig_i
// is resynchronised anyway since it comes from the system controller.
//
// Functional notes
// - global: reset all, sample all, read rows
// - pipelined: integrate frame N during N-1 readout
// - each global readout opens with frame overhead transfer
// - row overhead precedes every line readout
// - pipelined master: register exposure, free running
// - pipelined slave: ignore exposure register
// - slave: trigger high integrates, low samples
// - triggered: one frame per trigger, then idle
// - triggered: array held reset between frames
// - triggered: controller may overlap integration, readout
// - triggered master: rising edge starts timed frame
// - triggered master: falling edge has no effect
// - triggered master: early rising edge ignored
// - triggered slave: trigger bounds integration, reassert
// - rolling: separate reset and read pointers
// - rolling: rows streamed in order, equal exposure
// - rolling: reset node, then transfer signal
// - six power states, moved by user actions
// - low power standby: clocks, blocks off
// - low power standby: only clock registers reachable
// - standby one: clock source on, logic off
// - standby two: logic clock, all registers
// - idle: all but sequencer; enable starts run
`timescale 1ns/1ns
`default_nettype none

module smseq_top
	import smseq_pkg::*;
#(
	parameter int ROW_W = 16, // row pointer width
	parameter int EXPO_W = 32 // exposure counter width
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic trig_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic [1:0] avs_response_o,
	output var smseq_core_s core_o,
	output var smseq_pwr_s pwr_o,
	output logic frame_start_o,
	output logic line_valid_o
);

	// sequencer states for the readout engine of global and rolling modes
	typedef enum logic [2:0] {
		SMSEQ_RD_IDLE,
		SMSEQ_RD_FOP,
		SMSEQ_RD_ROP,
		SMSEQ_RD_LINE
	} smseq_rd_e;

	// integration engine states
	typedef enum logic [1:0] {
		SMSEQ_IN_RESET,
		SMSEQ_IN_INTEG,
		SMSEQ_IN_WAIT
	} smseq_in_e;

	// registers
	logic [31:0] ctrl_r; // mode, slave, enable, power request
	logic [31:0] expo_r; // exposure cycles
	logic [15:0] rows_r; // rows per frame
	logic ack_r; // one-cycle bus answer
	logic [31:0] rdata_r; // read data holding
	logic [1:0] resp_r; // response code

	// trigger synchroniser and edges
	logic trig_s1_r; // first stage, read only by second
	logic trig_s2_r; // second stage
	logic trig_d_r; // delayed copy for edges
	logic trig_rise; // rising edge
	logic trig_fall; // falling edge

	// engines
	smseq_rd_e rd_st_r; // readout state
	smseq_in_e in_st_r; // integration state
	logic [31:0] rd_cnt_r; // readout timing counter
	logic [EXPO_W-1:0] in_cnt_r; // exposure counter
	logic [ROW_W-1:0] rd_row_r; // readout pointer
	logic [ROW_W-1:0] rst_row_r; // rolling reset pointer
	logic rst_run_r; // reset pointer walking
	logic [EXPO_W-1:0] roll_cnt_r; // rolling reset row period counter
	logic [1:0] roll_ph_r; // rolling per-row phase
	logic sample_go; // integration end, start frame overhead
	smseq_pwr_e pwr_st_r; // power state

	// decoded controls
	smseq_mode_e mode;
	logic slave_md; // exposure from trigger
	logic seq_req; // sequencer enable bit
	smseq_pwr_e pwr_req; // requested power state
	logic run_en; // sequencer allowed to run
	logic wr_go; // write taken this cycle
	logic rd_go; // read taken this cycle
	logic reg_ok; // register reachable in this power state

	assign mode = smseq_mode_e'(ctrl_r[SMSEQ_CTRL_MODE_LSB +: 2]);
	assign slave_md = ctrl_r[SMSEQ_CTRL_SLAVE_BIT];
	assign seq_req = ctrl_r[SMSEQ_CTRL_SEQ_EN_BIT];
	assign pwr_req = smseq_pwr_e'(ctrl_r[SMSEQ_CTRL_PWR_LSB +: 3]);
	assign run_en = (pwr_st_r == SMSEQ_PWR_RUN);

	// byte-lane merge used by every register write
	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return res;
	endfunction

	// bus answers one cycle after the request is seen
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
	assign wr_go = avs_write_i & ack_r;
	assign rd_go = avs_read_i & ack_r;
	assign avs_readdata_o = rdata_r;
	assign avs_response_o = resp_r;

	// in low power standby only the control word is reachable
	assign reg_ok = (pwr_st_r != SMSEQ_PWR_LPSTBY) ||
		(avs_address_i == SMSEQ_OFS_CTRL);

	// ack toggles so every access takes exactly two cycles
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
		end
	end

	// register writes; contents survive every power state
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_r <= SMSEQ_CTRL_RST;
			expo_r <= SMSEQ_EXPO_RST;
			rows_r <= SMSEQ_ROWS_RST;
		end else if (wr_go && reg_ok) begin
			case (avs_address_i)
				SMSEQ_OFS_CTRL: ctrl_r <= be_merge(ctrl_r, avs_writedata_i,
					avs_byteenable_i) & 32'h0000_007F;
				SMSEQ_OFS_EXPO: expo_r <= be_merge(expo_r, avs_writedata_i,
					avs_byteenable_i);
				// only the low half of the geometry word exists
				SMSEQ_OFS_GEOM: rows_r <= 16'(be_merge({16'h0000, rows_r},
					avs_writedata_i, avs_byteenable_i));
				// status and unmapped offsets take no write
				default: ;
			endcase
		end
	end

	// read data and response, slave error on locked offsets, decode error on unmapped ones
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_r <= 32'h0000_0000;
			resp_r <= 2'h0;
		end else if (avs_read_i | avs_write_i) begin
			resp_r <= 2'h0;
			rdata_r <= 32'h0000_0000;
			if (!reg_ok) begin
				resp_r <= 2'h2;
			end else begin
				case (avs_address_i)
					SMSEQ_OFS_CTRL: rdata_r <= ctrl_r;
					SMSEQ_OFS_EXPO: rdata_r <= expo_r;
					SMSEQ_OFS_GEOM: rdata_r <= {16'h0000, rows_r};
					SMSEQ_OFS_STAT: begin
						rdata_r <= {16'h0000, rd_row_r[7:0],
							1'b0, pwr_st_r, rd_st_r[1:0], in_st_r};
					end
					default: resp_r <= 2'h3;
				endcase
			end
		end
	end

	// power state follows software requests one step at a time
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pwr_st_r <= SMSEQ_PWR_LPSTBY;
		end else if (pwr_req > pwr_st_r && pwr_st_r != SMSEQ_PWR_IDLE) begin
			pwr_st_r <= smseq_pwr_e'(pwr_st_r + 3'h1);
		end else if (pwr_st_r == SMSEQ_PWR_IDLE && seq_req) begin
			pwr_st_r <= SMSEQ_PWR_RUN;
		end else if (pwr_st_r == SMSEQ_PWR_RUN && !seq_req) begin
			pwr_st_r <= SMSEQ_PWR_IDLE;
		end else if (pwr_req < pwr_st_r && pwr_req != SMSEQ_PWR_OFF &&
			pwr_st_r != SMSEQ_PWR_RUN) begin
			pwr_st_r <= smseq_pwr_e'(pwr_st_r - 3'h1);
		end
	end

	// enables per power state
	always_comb begin
		pwr_o = '0;
		case (pwr_st_r)
			SMSEQ_PWR_STBY1: pwr_o.clk_src_en = 1'b1;
			SMSEQ_PWR_STBY2: begin
				pwr_o.clk_src_en = 1'b1;
				pwr_o.logic_clk_en = 1'b1;
				pwr_o.full_regs = 1'b1;
			end
			SMSEQ_PWR_IDLE, SMSEQ_PWR_RUN: begin
				pwr_o.clk_src_en = 1'b1;
				pwr_o.logic_clk_en = 1'b1;
				pwr_o.full_regs = 1'b1;
				pwr_o.blocks_en = 1'b1;
				pwr_o.seq_en = run_en;
			end
			default: pwr_o = '0; // off and low power standby
		endcase
	end

	// trigger synchroniser; only the second stage feeds logic
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			trig_s1_r <= 1'b0;
			trig_s2_r <= 1'b0;
			trig_d_r <= 1'b0;
		end else begin
			trig_s1_r <= trig_i;
			trig_s2_r <= trig_s1_r;
			trig_d_r <= trig_s2_r;
		end
	end
	assign trig_rise = trig_s2_r & ~trig_d_r;
	assign trig_fall = ~trig_s2_r & trig_d_r;

	// integration engine for both global modes
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			in_st_r <= SMSEQ_IN_RESET;
			in_cnt_r <= '0;
		end else if (!run_en || mode == SMSEQ_MODE_ROLL) begin
			in_st_r <= SMSEQ_IN_RESET;
			in_cnt_r <= '0;
		end else begin
			case (in_st_r)
				SMSEQ_IN_RESET: begin
					in_cnt_r <= '0;
					if (slave_md ? trig_rise :
						(mode == SMSEQ_MODE_PIPE || trig_rise)) begin
						in_st_r <= SMSEQ_IN_INTEG;
					end
				end
				SMSEQ_IN_INTEG: begin
					in_cnt_r <= in_cnt_r + 1'b1;
					if (slave_md ? trig_fall :
						(in_cnt_r + 1'b1 >= expo_r[EXPO_W-1:0])) begin
						in_st_r <= SMSEQ_IN_WAIT;
					end
				end
				SMSEQ_IN_WAIT: begin
					// held until this frame's overhead ends; edges meanwhile lost
					if (rd_st_r == SMSEQ_RD_FOP && rd_cnt_r == 32'(SMSEQ_FOP_CYC - 1)) begin
						in_st_r <= SMSEQ_IN_RESET;
					end
				end
				default: in_st_r <= SMSEQ_IN_RESET;
			endcase
		end
	end

	// exposure end hands over to the readout engine
	assign sample_go = (in_st_r == SMSEQ_IN_WAIT) &&
		(rd_st_r == SMSEQ_RD_IDLE); // pipe waits here for the last readout

	// readout engine: frame overhead in global modes, then row overhead per line
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_st_r <= SMSEQ_RD_IDLE;
			rd_cnt_r <= '0;
			rd_row_r <= '0;
		end else if (!run_en) begin
			rd_st_r <= SMSEQ_RD_IDLE;
			rd_cnt_r <= '0;
			rd_row_r <= '0;
		end else begin
			case (rd_st_r)
				SMSEQ_RD_IDLE: begin
					rd_cnt_r <= '0;
					rd_row_r <= '0;
					if (mode == SMSEQ_MODE_ROLL) begin
						rd_st_r <= SMSEQ_RD_ROP;
					end else if (sample_go) begin
						rd_st_r <= SMSEQ_RD_FOP;
					end
				end
				SMSEQ_RD_FOP: begin
					rd_cnt_r <= rd_cnt_r + 32'h1;
					if (rd_cnt_r == 32'(SMSEQ_FOP_CYC - 1)) begin
						rd_cnt_r <= '0;
						rd_st_r <= SMSEQ_RD_ROP;
					end
				end
				SMSEQ_RD_ROP: begin
					rd_cnt_r <= rd_cnt_r + 32'h1;
					if (rd_cnt_r == 32'(SMSEQ_ROP_CYC - 1)) begin
						rd_cnt_r <= '0;
						rd_st_r <= SMSEQ_RD_LINE;
					end
				end
				SMSEQ_RD_LINE: begin
					rd_cnt_r <= rd_cnt_r + 32'h1;
					if (rd_cnt_r == 32'(SMSEQ_LINE_CYC - 1)) begin
						rd_cnt_r <= '0;
						if (rd_row_r == ROW_W'(rows_r - 16'h1)) begin
							rd_row_r <= '0;
							// one frame per trigger; rolling streams on
							rd_st_r <= (mode == SMSEQ_MODE_ROLL) ?
								SMSEQ_RD_ROP : SMSEQ_RD_IDLE;
						end else begin
							rd_row_r <= rd_row_r + 1'b1;
							rd_st_r <= SMSEQ_RD_ROP;
						end
					end
				end
				default: rd_st_r <= SMSEQ_RD_IDLE;
			endcase
		end
	end

	// rolling reset pointer starts at row 0 with the read pointer; exposure register unused
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rst_row_r <= '0;
			rst_run_r <= 1'b0;
			roll_cnt_r <= '0;
		end else if (!run_en || mode != SMSEQ_MODE_ROLL) begin
			rst_row_r <= '0;
			rst_run_r <= 1'b0;
			roll_cnt_r <= '0;
		end else begin
			rst_run_r <= 1'b1;
			roll_cnt_r <= roll_cnt_r + 1'b1;
			// one row per line period, same pace as readout
			if (roll_cnt_r == EXPO_W'(SMSEQ_ROP_CYC + SMSEQ_LINE_CYC - 1)) begin
				roll_cnt_r <= '0;
				if (rst_row_r == ROW_W'(rows_r - 16'h1)) begin
					rst_row_r <= '0;
				end else begin
					rst_row_r <= rst_row_r + 1'b1;
				end
			end
		end
	end

	// rolling row phase: node reset in first overhead half, then transfer
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			roll_ph_r <= 2'h0;
		end else if (mode == SMSEQ_MODE_ROLL && rd_st_r == SMSEQ_RD_ROP) begin
			roll_ph_r <= (rd_cnt_r < 32'(SMSEQ_ROP_CYC / 2)) ? 2'h1 : 2'h2;
		end else begin
			roll_ph_r <= 2'h0;
		end
	end

	// image core drive
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			core_o <= '0;
			frame_start_o <= 1'b0;
			line_valid_o <= 1'b0;
		end else begin
			core_o.global_reset <= (mode != SMSEQ_MODE_ROLL) &&
				(in_st_r == SMSEQ_IN_RESET);
			core_o.global_sample <= (rd_st_r == SMSEQ_RD_FOP);
			core_o.row_reset <= rst_run_r;
			core_o.node_reset <= (roll_ph_r == 2'h1);
			core_o.row_transfer <= (roll_ph_r == 2'h2);
			core_o.row_select <= (rd_st_r == SMSEQ_RD_LINE);
			core_o.rst_row <= 16'(rst_row_r);
			core_o.rd_row <= 16'(rd_row_r);
			frame_start_o <= sample_go && rd_st_r == SMSEQ_RD_IDLE;
			line_valid_o <= (rd_st_r == SMSEQ_RD_LINE);
		end
	end
endmodule

`default_nettype wire

// ==== smseq_pkg.sv ====
// smseq_pkg: shared constants and types for the shutter mode sequencer.
// assumes a single 10 MHz logic clock; all times are counted in its cycles.
package smseq_pkg;

	// register byte offsets, one aligned 32-bit word each
	localparam logic [3:0] SMSEQ_OFS_CTRL = 4'h0; // mode, enables, power
	localparam logic [3:0] SMSEQ_OFS_EXPO = 4'h4; // exposure in cycles
	localparam logic [3:0] SMSEQ_OFS_GEOM = 4'h8; // rows per frame
	localparam logic [3:0] SMSEQ_OFS_STAT = 4'hC; // sequencer state view

	// control register field positions
	localparam int SMSEQ_CTRL_MODE_LSB = 0; // 2-bit shutter mode
	localparam int SMSEQ_CTRL_SLAVE_BIT = 2; // 1 = trigger sets exposure
	localparam int SMSEQ_CTRL_SEQ_EN_BIT = 3; // sequencer enable
	localparam int SMSEQ_CTRL_PWR_LSB = 4; // 3-bit power request

	// reset values
	localparam logic [31:0] SMSEQ_CTRL_RST = 32'h0000_0010;
	localparam logic [31:0] SMSEQ_EXPO_RST = 32'h0000_0100;
	localparam logic [15:0] SMSEQ_ROWS_RST = 16'h0400;

	// timing: overheads as printed in ns, counts derived at 10 MHz
	localparam int SMSEQ_CLK_PERIOD_NS = 100;
	localparam int SMSEQ_FOP_NS = 20000; // frame overhead time
	localparam int SMSEQ_ROP_NS = 1000; // row overhead time
	localparam int SMSEQ_LINE_NS = 12800; // line readout time
	localparam int SMSEQ_FOP_CYC =
		(SMSEQ_FOP_NS + SMSEQ_CLK_PERIOD_NS - 1) / SMSEQ_CLK_PERIOD_NS;
	localparam int SMSEQ_ROP_CYC =
		(SMSEQ_ROP_NS + SMSEQ_CLK_PERIOD_NS - 1) / SMSEQ_CLK_PERIOD_NS;
	localparam int SMSEQ_LINE_CYC =
		(SMSEQ_LINE_NS + SMSEQ_CLK_PERIOD_NS - 1) / SMSEQ_CLK_PERIOD_NS;

	// shutter modes
	typedef enum logic [1:0] {
		SMSEQ_MODE_PIPE = 2'h0,
		SMSEQ_MODE_TRIG = 2'h1,
		SMSEQ_MODE_ROLL = 2'h2
	} smseq_mode_e;

	// power and clock states, ordered by power
	typedef enum logic [2:0] {
		SMSEQ_PWR_OFF = 3'h0,
		SMSEQ_PWR_LPSTBY = 3'h1,
		SMSEQ_PWR_STBY1 = 3'h2,
		SMSEQ_PWR_STBY2 = 3'h3,
		SMSEQ_PWR_IDLE = 3'h4,
		SMSEQ_PWR_RUN = 3'h5
	} smseq_pwr_e;

	// image core control bundle
	typedef struct packed {
		logic global_reset; // whole array held in reset
		logic global_sample; // photodiode to pixel memory
		logic row_reset; // rolling reset of rst_row
		logic node_reset; // storage node reset before transfer
		logic row_transfer; // transfer of integrated signal
		logic row_select; // readout of rd_row
		logic [15:0] rst_row; // rolling reset pointer
		logic [15:0] rd_row; // readout pointer
	} smseq_core_s;

	// clock and block enables per power state
	typedef struct packed {
		logic clk_src_en; // pll or lvds receiver
		logic logic_clk_en; // derived logic clock
		logic blocks_en; // all blocks except sequencer
		logic seq_en; // sequencer running
		logic full_regs; // all config registers reachable
	} smseq_pwr_s;

endpackage

// ==== smseq_checker.sv ====
// smseq_checker: port-level timing relations of the shutter sequencer.
// assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none

module smseq_checker
	import smseq_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic [1:0] avs_response_o,
	input wire smseq_core_s core_o,
	input wire smseq_pwr_s pwr_o,
	input wire logic frame_start_o,
	input wire logic line_valid_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	// every access: one cycle of wait, then the answer
	sequence s_answer;
		avs_waitrequest_o ##1 !avs_waitrequest_o;
	endsequence
	// frame overhead: no line may start for a while
	sequence s_fop_quiet;
		!line_valid_o ##1 !line_valid_o [*8];
	endsequence

	a_bus_answer: assert property ($rose(avs_read_i || avs_write_i) |-> s_answer)
		else $error("bus answer not in second cycle");
	a_lp_locked: assert property (avs_read_i && !avs_waitrequest_o &&
		avs_address_i == SMSEQ_OFS_EXPO && !pwr_o.clk_src_en |->
		avs_response_o == 2'h2) else $error("locked register answered");
	a_bad_addr: assert property (avs_read_i && !avs_waitrequest_o &&
		avs_address_i[1:0] != 2'h0 && pwr_o.clk_src_en |->
		avs_response_o == 2'h3 && avs_readdata_o == 32'h0)
		else $error("unmapped read not refused");
	a_lp_all_off: assert property (!pwr_o.clk_src_en |-> pwr_o == '0)
		else $error("block enabled without clock source");
	a_blocks_need: assert property (pwr_o.blocks_en |->
		pwr_o.logic_clk_en && pwr_o.full_regs)
		else $error("blocks enabled without logic clock");
	a_seq_need: assert property (pwr_o.seq_en |-> pwr_o.blocks_en)
		else $error("sequencer enabled outside idle chain");
	a_pwr_step: assert property ($rose(pwr_o.blocks_en) |->
		$past(pwr_o.logic_clk_en)) else $error("power state skipped");
	a_fop_quiet: assert property (frame_start_o |-> s_fop_quiet)
		else $error("line during frame overhead");
	a_fs_pulse: assert property (frame_start_o |=> !frame_start_o)
		else $error("frame start longer than one cycle");
	a_row_gap: assert property ($fell(line_valid_o) |=> !line_valid_o [*8])
		else $error("row overhead missing");
	a_sample_all: assert property (core_o.global_sample |->
		!core_o.global_reset) else $error("sample during array reset");
	a_node_first: assert property ($rose(core_o.node_reset) |->
		##[1:300] core_o.row_transfer) else $error("no transfer after node reset");
endmodule

bind smseq_top smseq_checker i_chk (.clk_i, .sys_rst_i, .avs_address_i,
	.avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o,
	.avs_response_o, .core_o, .pwr_o, .frame_start_o, .line_valid_o);

`default_nettype wire

// ==== smseq_ctrl_model.sv ====
// smseq_ctrl_model: system controller that drives the trigger pin.
// assumes the caller asks for one pulse at a time.
`timescale 1ns/1ns
`default_nettype none

module smseq_ctrl_model (
	input wire logic clk_i,
	output logic trig_o
);
	// trigger idles low; it is always driven, never floating
	initial trig_o = 1'b0;

	// raise after an edge, hold exactly hold cycles, then drop
	task automatic pulse(input int hold);
		@(posedge clk_i);
		trig_o <= 1'b1;
		repeat (hold) @(posedge clk_i);
		trig_o <= 1'b0;
	endtask
endmodule

`default_nettype wire

// ==== smseq_tb_top.sv ====
// smseq_tb_top: self-checking bench for the shutter sequencer.
// assumes the checker is bound by its own file and a 10 MHz clock.
`timescale 1ns/1ns
`default_nettype none

module smseq_tb_top;
	import smseq_pkg::*;
	typedef struct {logic [1:0] resp; logic [31:0] data; bit chk;} smseq_note_s;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1; // held for the first 12 cycles
	logic trig_i; // driven by the controller model
	logic [3:0] avs_address_i = 4'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0] avs_byteenable_i = 4'hF; // full words only
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic [1:0] avs_response_o;
	smseq_core_s core_o;
	smseq_pwr_s pwr_o;
	logic frame_start_o;
	logic line_valid_o;
	int error_cnt = 0;
	int checks = 0;
	int fs_cnt = 0; // frame starts seen
	int ln_cnt = 0; // lines seen
	int expo; // programmed exposure, cycles
	logic [15:0] rd_last = 16'h0; // read row of the last line
	logic [15:0] rd_prev = 16'h0; // read row of the line before
	logic lv_d = 1'b0; // line valid one cycle back
	smseq_note_s note_q[$]; // expected read answers, oldest first
	logic [4:0] pwr_exp[2:4] = '{5'h10, 5'h19, 5'h1D};
	logic [3:0] slv_modes[2] = '{4'hD, 4'hC}; // triggered, pipelined

	smseq_top i_dut (.clk_i, .sys_rst_i, .trig_i, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
		.avs_waitrequest_o, .avs_response_o, .core_o, .pwr_o, .frame_start_o,
		.line_valid_o);
	smseq_ctrl_model i_ctrl (.clk_i, .trig_o(trig_i));

	// 100 ns period
	always #50 clk_i = ~clk_i;

	task automatic give_verdict();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic fail(input string what, input logic [31:0] e,
		input logic [31:0] g);
		error_cnt++;
		$display("[FAIL] %s expected %h seen %h", what, e, g);
	endtask

	task automatic cmp_val(input string what, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) fail(what, e, g);
	endtask

	// measured counts and the rolling reset row; never design values
	task automatic cmp_rng(input string what, input int lo, input int hi,
		input int g);
		checks++;
		if (g < lo || g > hi) fail(what, lo, g);
	endtask

	// one access; the request stands until a rising edge sees waitrequest
	// low, and is dropped at that very edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		for (n = 0; n < 20; n++) begin
			@(posedge clk_i);
			if (avs_waitrequest_o === 1'b0) break;
		end
		if (n == 20) begin
			fail("bus wait", 32'h0, 32'(n));
			give_verdict();
		end
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] r, input bit chk);
		note_q.push_back('{r, d, chk});
		bus(1'b0, a, 32'h0);
	endtask

	// bounded wait on a counter; t returns the cycles it took
	task automatic wait_cnt(ref int c, input int tgt, input int lim,
		output int t);
		for (t = 0; t < lim && c < tgt; t++) @(posedge clk_i);
		if (c < tgt) begin
			fail("event wait", 32'(tgt), 32'(c));
			give_verdict();
		end
	endtask

	// stop the sequencer in idle, then start it in mode m
	task automatic go(input logic [3:0] m);
		bus(1'b1, SMSEQ_OFS_CTRL, 32'h40);
		repeat (4) @(posedge clk_i);
		bus(1'b1, SMSEQ_OFS_CTRL, 32'h40 | 32'(m));
	endtask

	// read answers are taken at the edge that sees waitrequest low
	always @(posedge clk_i) begin
		if (avs_read_i && avs_waitrequest_o === 1'b0) begin
			if (note_q.size() == 0) begin
				fail("unexpected read", 32'h0, avs_readdata_o);
			end else begin
				cmp_val("read resp", 32'(note_q[0].resp), 32'(avs_response_o));
				if (note_q[0].chk) cmp_val("read data", note_q[0].data, avs_readdata_o);
				void'(note_q.pop_front());
			end
		end
	end

	// count frames and lines; remember the rows just read
	always @(posedge clk_i) begin
		if (frame_start_o === 1'b1) fs_cnt++;
		if (line_valid_o === 1'b1 && lv_d === 1'b0) begin
			ln_cnt++;
			rd_prev <= rd_last;
			rd_last <= core_o.rd_row;
		end
		lv_d <= line_valid_o;
	end

	initial begin
		int t;
		int hold;
		t = $urandom(42567);
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		cmp_val("pwr lp", 32'h0, 32'(pwr_o));
		rd(SMSEQ_OFS_CTRL, SMSEQ_CTRL_RST, 2'h0, 1);
		rd(SMSEQ_OFS_EXPO, 32'h0, 2'h2, 0);
		bus(1'b1, SMSEQ_OFS_EXPO, $urandom);
		// climb one power state at a time
		for (int p = 2; p <= 4; p++) begin
			bus(1'b1, SMSEQ_OFS_CTRL, 32'(p) << 4);
			repeat (4) @(posedge clk_i);
			cmp_val("pwr state", 32'(pwr_exp[p]), 32'(pwr_o));
		end
		rd(SMSEQ_OFS_EXPO, SMSEQ_EXPO_RST, 2'h0, 1);
		rd(SMSEQ_OFS_GEOM, 32'(SMSEQ_ROWS_RST), 2'h0, 1);
		rd(4'h6, 32'h0, 2'h3, 1);
		// short exposure and two rows keep every frame brief
		expo = 20 + $urandom % 16;
		bus(1'b1, SMSEQ_OFS_EXPO, 32'(expo));
		bus(1'b1, SMSEQ_OFS_GEOM, 32'h2);
		// triggered master
		go(4'h9);
		repeat (4) @(posedge clk_i);
		cmp_val("pwr run", 32'h1F, 32'(pwr_o));
		repeat (300) @(posedge clk_i);
		cmp_val("idle frames", 32'h0, 32'(fs_cnt));
		cmp_val("array reset", 32'h1, 32'(core_o.global_reset));
		i_ctrl.pulse(5);
		i_ctrl.pulse(3); // second edge lands inside integration
		wait_cnt(fs_cnt, 1, 400, t);
		cmp_rng("expo delay", expo - 10, expo + 2, t);
		wait_cnt(ln_cnt, 2, 1000, t);
		repeat (100) @(posedge clk_i);
		cmp_val("one frame", 32'h1, 32'(fs_cnt));
		cmp_val("reset again", 32'h1, 32'(core_o.global_reset));
		i_ctrl.pulse(2);
		wait_cnt(fs_cnt, 2, 400, t);
		repeat (600) @(posedge clk_i);
		// slave modes: trigger length sets the exposure
		foreach (slv_modes[i]) begin
			go(slv_modes[i]);
			hold = 40 + $urandom % 20;
			t = fs_cnt;
			fork
				i_ctrl.pulse(hold);
				begin
					repeat (hold / 2 + 1) @(posedge clk_i);
					cmp_val("integrating", 32'h0, 32'(core_o.global_reset));
				end
			join
			wait_cnt(fs_cnt, t + 1, 50, hold);
			cmp_rng("fall delay", 1, 8, hold);
			repeat (600) @(posedge clk_i);
		end
		// pipelined master: frames run on with the trigger low
		go(4'h8);
		t = fs_cnt;
		wait_cnt(fs_cnt, t + 1, 2000, hold);
		wait_cnt(fs_cnt, t + 2, 2000, hold);
		cmp_rng("frame period", 470, 470 + expo, hold);
		// rolling: rows read in turn
		go(4'hA);
		t = ln_cnt;
		wait_cnt(ln_cnt, t + 3, 3000, hold);
		@(posedge clk_i);
		cmp_val("row order", 32'h1, 32'((rd_last - rd_prev) % 2));
		cmp_val("row select", 32'h1, 32'(core_o.row_select));
		cmp_val("reset walking", 32'h1, 32'(core_o.row_reset));
		cmp_rng("reset row", 0, 1, int'(core_o.rst_row));
		bus(1'b1, SMSEQ_OFS_CTRL, 32'h40);
		repeat (4) @(posedge clk_i);
		cmp_val("pwr idle", 32'h1D, 32'(pwr_o));
		give_verdict();
	end
endmodule

`default_nettype wire
